// [bench/bpcs_host_model.sv]
// host side of the primary config path: one bench request becomes one access.
// assumes the bench raises go_i for one cycle and then waits for done_o.
`default_nettype none

module bpcs_host_model (
    // clock and reset
    input  wire logic                       clk_i,
    input  wire logic                       rst_n_i,
    // bench side
    input  wire logic                       go_i,
    input  wire bpcs_pkg::bpcs_cfg_req_type op_i,
    output logic                            done_o,
    output logic [31:0]                     rdata_o,
    // device side
    output bpcs_pkg::bpcs_cfg_req_type      cfg_req_o,
    input  wire logic                       cfg_ack_i,
    input  wire logic [31:0]                cfg_rdata_i
);
    timeunit 1ns;
    timeprecision 1ps;
    import bpcs_pkg::*;

    // idle cycles clear valid and invert the other fields so stale values never look valid
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            cfg_req_o <= '0;
            done_o    <= 1'b0;
            rdata_o   <= 32'h0;
        end else begin
            cfg_req_o <= go_i ? op_i : {1'b0, ~cfg_req_o[40:0]};
            done_o    <= cfg_ack_i;
            if (cfg_ack_i) begin
                rdata_o <= cfg_rdata_i;
            end
        end
    end
endmodule : bpcs_host_model

`default_nettype wire

// [bench/test_bridge_primary_command_status.sv]
// self-checking bench for the primary command/status register pair.
// assumes the package, design and host model are compiled before it.
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin error_cnt++; \
    $display("[ERR] %s exp %h got %h", nm, e, g); end end

module test_bridge_primary_command_status;
    timeunit 1ns;
    timeprecision 1ps;
    import bpcs_pkg::*;

    localparam bpcs_evt_type ev_none = '0;
    localparam bpcs_evt_type ev_all  = '1;

    logic             clk_i;
    logic             rst_n_i;
    logic             go;
    bpcs_cfg_req_type op;
    logic             done;
    logic [31:0]      rdata;
    bpcs_cfg_req_type cfg_req;
    logic             cfg_ack;
    logic [31:0]      cfg_rdata;
    logic             io_wr_valid;
    logic [9:0]       io_addr;
    bpcs_evt_type     evt;
    logic             perr_n;
    logic             serr;
    logic             serr_oe;
    bpcs_ctl_type     ctl;
    logic             vga_hit;
    logic [15:0]      command;
    logic [15:0]      status;
    logic [31:0]      rd;
    int               error_cnt = 0;
    int               n_tests = 0;

    bpcs_host_model host (.clk_i(clk_i), .rst_n_i(rst_n_i), .go_i(go), .op_i(op), .done_o(done),
        .rdata_o(rdata), .cfg_req_o(cfg_req), .cfg_ack_i(cfg_ack), .cfg_rdata_i(cfg_rdata));

    bpcs_cmd_status dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .cfg_req_i(cfg_req), .cfg_ack_o(cfg_ack),
        .cfg_rdata_o(cfg_rdata), .io_wr_valid_i(io_wr_valid), .io_addr_i(io_addr), .evt_i(evt),
        .primary_parity_error_pin_n_i(perr_n), .primary_system_error_pin_o(serr),
        .primary_system_error_pin_oe_o(serr_oe), .ctl_o(ctl), .vga_palette_hit_o(vga_hit),
        .command_o(command), .status_o(status));

    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end

    // events and the parity pin land in the cycle the request is taken
    task automatic access(input logic wr, input logic [3:0] idx, input logic [3:0] be,
                          input logic [31:0] wd, input bpcs_evt_type ev, input logic perr,
                          input logic [15:0] cmd_now);
        int n;
        @(posedge clk_i);
        go <= 1'b1;
        op <= '{valid: 1'b1, write: wr, idx: idx, be: be, data: wd};
        @(posedge clk_i);
        go     <= 1'b0;
        evt    <= ev;
        perr_n <= ~perr;
        #1;
        `CHK("serr_oe", ev.serr_request & cmd_now[8], serr_oe);
        @(posedge clk_i);
        evt    <= ev_none;
        perr_n <= 1'b1;
        for (n = 0; n < 8 && done !== 1'b1; n++) begin
            @(posedge clk_i);
            #1;
        end
        `CHK("done", 1'b1, done);
        rd = rdata;
    endtask : access

    task automatic vga_sweep(input logic en);
        logic [9:0] a [4];
        a = '{10'h3c6, 10'h3c8, 10'h3c9, 10'h3c7};
        for (int i = 0; i < 4; i++) begin
            @(posedge clk_i);
            io_wr_valid <= 1'b1;
            io_addr     <= a[i];
            #1;
            `CHK("vga_hit", en && i < 3, vga_hit);
        end
        @(posedge clk_i);
        io_wr_valid <= 1'b0;
    endtask : vga_sweep

    task automatic print_verdict();
        if (error_cnt == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : print_verdict

    initial begin
        #(40 * 2000);
        error_cnt++;
        print_verdict();
    end

    initial begin
        rst_n_i     = 1'b0;
        go          = 1'b0;
        op          = '0;
        io_wr_valid = 1'b0;
        io_addr     = 10'h0;
        evt         = ev_none;
        perr_n      = 1'b1;
        repeat (20) @(posedge clk_i);
        rst_n_i <= 1'b1;
        access(1'b0, 4'h1, 4'hf, 32'h0, ev_none, 1'b0, 16'h0);
        `CHK("reset view", 32'h02b0_0000, rd);
        `CHK("serr data", 1'b0, serr);
        vga_sweep(1'b0);
        // events while parity response and serr driver are off
        access(1'b0, 4'h2, 4'hf, 32'h0, ev_all, 1'b1, 16'h0);
        `CHK("other idx", 32'h0, rd);
        access(1'b0, 4'h1, 4'hf, 32'h0, ev_none, 1'b0, 16'h0);
        `CHK("gated flags", 32'hbab0_0000, rd);
        // command bytes only: read-only and reserved bits stay zero
        access(1'b1, 4'h1, 4'h3, 32'hffff_ffff, ev_none, 1'b0, 16'h0);
        access(1'b0, 4'h1, 4'hf, 32'h0, ev_none, 1'b0, 16'h0367);
        `CHK("cmd ones", 32'hbab0_0367, rd);
        `CHK("command", 16'h0367, command);
        `CHK("ctl", 6'b111110, ctl);
        vga_sweep(1'b1);
        // clear every status flag while every event fires: sets win
        access(1'b1, 4'h1, 4'hc, 32'hffff_0000, ev_all, 1'b1, 16'h0367);
        access(1'b0, 4'h1, 4'hf, 32'h0, ev_none, 1'b0, 16'h0367);
        `CHK("set wins", 32'hfbb0_0367, rd);
        access(1'b1, 4'h1, 4'hc, 32'h0900_0000, ev_none, 1'b0, 16'h0367);
        access(1'b0, 4'h1, 4'hf, 32'h0, ev_none, 1'b0, 16'h0367);
        `CHK("w1c part", 32'hf2b0_0367, rd);
        access(1'b1, 4'h1, 4'hf, 32'hffff_0000, ev_none, 1'b0, 16'h0367);
        access(1'b1, 4'h3, 4'hf, 32'hffff_ffff, ev_none, 1'b0, 16'h0);
        access(1'b0, 4'h1, 4'hf, 32'h0, ev_none, 1'b0, 16'h0);
        `CHK("all clear", 32'h02b0_0000, rd);
        `CHK("ctl off", 6'b000000, ctl);
        `CHK("status", 16'h02b0, status);
        print_verdict();
    end
endmodule : test_bridge_primary_command_status

`default_nettype wire

// [src/bpcs_cmd_status.sv]
// primary command and status register pair of a pci-to-pci bridge.
// assumes the primary bus logic claims type-0 config cycles and
// presents them as single-cycle requests; events arrive as pulses.
`include "bpcs_defines.svh"
`default_nettype none

module bpcs_cmd_status (
    // clock and reset
    input  wire logic                       clk_i,
    input  wire logic                       rst_n_i,
    // configuration access
    input  wire bpcs_pkg::bpcs_cfg_req_type cfg_req_i,
    output logic                            cfg_ack_o,
    output logic [31:0]                     cfg_rdata_o,
    // primary decode inputs
    input  wire logic                       io_wr_valid_i,
    input  wire logic [9:0]                 io_addr_i,
    // events and pins
    input  wire bpcs_pkg::bpcs_evt_type     evt_i,
    input  wire logic                       primary_parity_error_pin_n_i,
    output logic                            primary_system_error_pin_o,
    output logic                            primary_system_error_pin_oe_o,
    // decode permissions and raw registers
    output bpcs_pkg::bpcs_ctl_type          ctl_o,
    output logic                            vga_palette_hit_o,
    output logic [15:0]                     command_o,
    output logic [15:0]                     status_o
);
    import bpcs_pkg::*;

    logic [15:0] cmd_reg;
    logic [15:0] cmd_next;
    logic [15:0] sts_reg;
    logic [15:0] sts_next;
    logic [15:0] sts_set;
    logic [15:0] sts_clr;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic        ack_reg;

    wire         hit_cmd_sts = cfg_req_i.valid && (cfg_req_i.idx == `BPCS_IDX_CMD_STS); // R23
    wire         wr_hit      = hit_cmd_sts && cfg_req_i.write;
    wire         rd_req      = cfg_req_i.valid && !cfg_req_i.write;
    wire [15:0]  cmd_be_mask = {{8{cfg_req_i.be[1]}}, {8{cfg_req_i.be[0]}}};
    wire [15:0]  sts_be_mask = {{8{cfg_req_i.be[3]}}, {8{cfg_req_i.be[2]}}};
    wire [15:0]  cmd_wmask   = cmd_be_mask & `BPCS_CMD_WR_MASK; // R4 R5 R8 R11

    // qualified strobes, named so the checks below can sample them
    wire         rd_hit      = rd_req && hit_cmd_sts;
    wire         cmd_lo_wr   = wr_hit && cfg_req_i.be[0];
    wire         cmd_hi_wr   = wr_hit && cfg_req_i.be[1];
    wire         sts_b2_wr   = wr_hit && cfg_req_i.be[2];
    wire         sts_b3_wr   = wr_hit && cfg_req_i.be[3];

    // writable bits only; read-only and reserved ones never load
    assign cmd_next = wr_hit ? ((cmd_reg & ~cmd_wmask) | (cfg_req_i.data[15:0] & cmd_wmask)) // R1 R2 R3 R6 R7 R9 R10
                             : cmd_reg;

    // system error is open drain: only pulled low, never driven high
    wire serr_drive = evt_i.serr_request && cmd_reg[`BPCS_CMD_SERR_EN]; // R9
    assign primary_system_error_pin_o    = 1'b0;
    assign primary_system_error_pin_oe_o = serr_drive; // R9

    wire perr_pin_seen = !primary_parity_error_pin_n_i && cmd_reg[`BPCS_CMD_PERR_RESP]; // R15

    always_comb begin
        sts_set = 16'h0000;
        sts_set[`BPCS_STS_DPE_MSTR]   = perr_pin_seen;            // R15
        sts_set[`BPCS_STS_SIG_TABORT] = evt_i.sig_target_abort;   // R17
        sts_set[`BPCS_STS_RCV_TABORT] = evt_i.rcv_target_abort;   // R18
        sts_set[`BPCS_STS_RCV_MABORT] = evt_i.rcv_master_abort;   // R19
        sts_set[`BPCS_STS_SIG_SERR]   = serr_drive;               // R20
        sts_set[`BPCS_STS_DET_PERR]   = evt_i.parity_detected;    // R21
    end

    assign sts_clr  = wr_hit ? (cfg_req_i.data[31:16] & sts_be_mask & `BPCS_STS_W1C_MASK) : 16'h0000; // R22
    // a set in the same cycle as a clear wins, so no event is lost
    assign sts_next = ((sts_reg & ~sts_clr) | sts_set) & `BPCS_STS_W1C_MASK; // R22

    // fixed capability bits are ored in at read time
    wire [15:0] sts_view = sts_reg | `BPCS_STS_FIXED; // R12 R13 R14 R16
    wire [15:0] cmd_view = cmd_reg & `BPCS_CMD_WR_MASK; // R4 R5 R8 R11

    // unclaimed dwords inside the header read zero here
    assign rdata_next = (rd_req && hit_cmd_sts) ? {sts_view, cmd_view} : 32'h0000_0000;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            cmd_reg   <= `BPCS_CMD_RESET;
            sts_reg   <= `BPCS_STS_RESET;
            rdata_reg <= 32'h0000_0000;
            ack_reg   <= 1'b0;
        end else begin
            cmd_reg   <= cmd_next;
            sts_reg   <= sts_next;
            rdata_reg <= rdata_next;
            ack_reg   <= cfg_req_i.valid;
        end
    end

    assign cfg_ack_o   = ack_reg;
    assign cfg_rdata_o = rdata_reg;
    assign command_o   = cmd_view;
    assign status_o    = sts_view;

    // palette snoop ignores ad[15:10] so isa aliases also match
    wire vga_addr_match = (io_addr_i == `BPCS_VGA_A0) || (io_addr_i == `BPCS_VGA_A1)
                       || (io_addr_i == `BPCS_VGA_A2);
    assign vga_palette_hit_o = io_wr_valid_i && vga_addr_match && cmd_reg[`BPCS_CMD_VGA_SNOOP]; // R6

    assign ctl_o.io_target_en   = cmd_reg[`BPCS_CMD_IO_EN];     // R1
    assign ctl_o.mem_target_en  = cmd_reg[`BPCS_CMD_MEM_EN];    // R2
    assign ctl_o.master_en      = cmd_reg[`BPCS_CMD_MASTER_EN]; // R3
    assign ctl_o.parity_resp_en = cmd_reg[`BPCS_CMD_PERR_RESP]; // R7
    assign ctl_o.fast_b2b_en    = cmd_reg[`BPCS_CMD_FB2B_EN];   // R10
    // stepping is never offered; the bit is not writable
    assign ctl_o.stepping_en    = cmd_reg[`BPCS_CMD_STEPPING];  // R8

    a_serr_needs_enable: assert property ( // R9
        @(posedge clk_i) disable iff (!rst_n_i)
        primary_system_error_pin_oe_o |-> command_o[`BPCS_CMD_SERR_EN])
        else $error("system error driven while disabled");

    a_reserved_cmd_zero: assert property ( // R11
        @(posedge clk_i) disable iff (!rst_n_i)
        (cfg_ack_o && $past(rd_hit))
        |-> (cfg_rdata_o[15:10] == 6'h00 && cfg_rdata_o[4:3] == 2'h0 && cfg_rdata_o[7] == 1'b0))
        else $error("reserved or read-only command bits not zero");

    a_fixed_status_bits: assert property ( // R16
        @(posedge clk_i) disable iff (!rst_n_i)
        status_o[26-16:25-16] == 2'b01 && status_o[`BPCS_STS_CAP_LIST]
        && status_o[`BPCS_STS_66MHZ] && status_o[`BPCS_STS_FB2B_CAP])
        else $error("fixed status bits wrong");

    a_io_en_write: assert property ( // R1
        @(posedge clk_i) disable iff (!rst_n_i)
        (cfg_req_i.valid && cfg_req_i.write && cfg_req_i.idx == `BPCS_IDX_CMD_STS && cfg_req_i.be[0])
        |=> ctl_o.io_target_en == $past(cfg_req_i.data[0]))
        else $error("io enable did not follow write");

    a_master_en_hold: assert property ( // R3
        @(posedge clk_i) disable iff (!rst_n_i)
        !(cfg_req_i.valid && cfg_req_i.write && cfg_req_i.be[0]) |=> $stable(ctl_o.master_en))
        else $error("master enable changed without write");

    a_vga_decode: assert property ( // R6
        @(posedge clk_i) disable iff (!rst_n_i)
        (io_wr_valid_i && command_o[`BPCS_CMD_VGA_SNOOP] && io_addr_i == `BPCS_VGA_A1)
        |-> vga_palette_hit_o)
        else $error("palette write not decoded");

    a_dpe_sets: assert property ( // R15
        @(posedge clk_i) disable iff (!rst_n_i)
        (!primary_parity_error_pin_n_i && command_o[`BPCS_CMD_PERR_RESP])
        |=> status_o[`BPCS_STS_DPE_MSTR])
        else $error("parity pin event lost");

    a_dpe_gated: assert property ( // R15
        @(posedge clk_i) disable iff (!rst_n_i)
        (!status_o[`BPCS_STS_DPE_MSTR] && !command_o[`BPCS_CMD_PERR_RESP])
        |=> !status_o[`BPCS_STS_DPE_MSTR])
        else $error("parity flag set while response off");

    a_abort_sets: assert property ( // R17
        @(posedge clk_i) disable iff (!rst_n_i)
        evt_i.sig_target_abort |=> status_o[`BPCS_STS_SIG_TABORT] [*1])
        else $error("signalled target abort lost");

    a_rx_aborts: assert property ( // R19
        @(posedge clk_i) disable iff (!rst_n_i)
        (evt_i.rcv_master_abort && evt_i.rcv_target_abort)
        |=> status_o[`BPCS_STS_RCV_MABORT] && status_o[`BPCS_STS_RCV_TABORT])
        else $error("received abort lost");

    a_serr_flag: assert property ( // R20
        @(posedge clk_i) disable iff (!rst_n_i)
        primary_system_error_pin_oe_o |=> status_o[`BPCS_STS_SIG_SERR])
        else $error("system error flag not set");

    a_perr_flag: assert property ( // R21
        @(posedge clk_i) disable iff (!rst_n_i)
        evt_i.parity_detected |=> status_o[`BPCS_STS_DET_PERR])
        else $error("detected parity flag not set");

    a_w1c_clear: assert property ( // R22
        @(posedge clk_i) disable iff (!rst_n_i)
        (cfg_req_i.valid && cfg_req_i.write && cfg_req_i.idx == `BPCS_IDX_CMD_STS
         && cfg_req_i.be[3] && cfg_req_i.data[31] && !evt_i.parity_detected)
        |=> !status_o[`BPCS_STS_DET_PERR])
        else $error("write one did not clear flag");

    a_w0_keeps: assert property ( // R22
        @(posedge clk_i) disable iff (!rst_n_i)
        (status_o[`BPCS_STS_RCV_TABORT] && !(cfg_req_i.valid && cfg_req_i.write
         && cfg_req_i.be[3] && cfg_req_i.data[28]))
        |=> status_o[`BPCS_STS_RCV_TABORT])
        else $error("flag dropped without write one");

    a_read_ack: assert property ( // R23
        @(posedge clk_i) disable iff (!rst_n_i)
        cfg_req_i.valid |=> cfg_ack_o ##1 (!cfg_ack_o || $past(cfg_req_i.valid)))
        else $error("config access not answered");

    a_mem_en_write: assert property ( // R2
        @(posedge clk_i) disable iff (!rst_n_i)
        cmd_lo_wr |=> ctl_o.mem_target_en == $past(cfg_req_i.data[1]))
        else $error("memory enable did not follow write");

    a_master_en_write: assert property ( // R3
        @(posedge clk_i) disable iff (!rst_n_i)
        cmd_lo_wr |=> ctl_o.master_en == $past(cfg_req_i.data[2]))
        else $error("master enable did not follow write");

    a_special_zero: assert property ( // R4
        @(posedge clk_i) disable iff (!rst_n_i)
        !command_o[`BPCS_CMD_SPECIAL])
        else $error("special cycle bit not zero");

    a_mwi_zero: assert property ( // R5
        @(posedge clk_i) disable iff (!rst_n_i)
        !command_o[`BPCS_CMD_MWI])
        else $error("write-invalidate bit not zero");

    a_vga_en_write: assert property ( // R6
        @(posedge clk_i) disable iff (!rst_n_i)
        cmd_lo_wr |=> command_o[`BPCS_CMD_VGA_SNOOP] == $past(cfg_req_i.data[5]))
        else $error("palette snoop enable did not follow write");

    a_vga_gated: assert property ( // R6
        @(posedge clk_i) disable iff (!rst_n_i)
        !command_o[`BPCS_CMD_VGA_SNOOP] |-> !vga_palette_hit_o)
        else $error("palette hit while snoop off");

    a_vga_miss: assert property ( // R6
        @(posedge clk_i) disable iff (!rst_n_i)
        (!io_wr_valid_i || io_addr_i == 10'h3c7) |-> !vga_palette_hit_o)
        else $error("palette hit on wrong access");

    a_perr_resp_write: assert property ( // R7
        @(posedge clk_i) disable iff (!rst_n_i)
        cmd_lo_wr |=> ctl_o.parity_resp_en == $past(cfg_req_i.data[6]))
        else $error("parity response did not follow write");

    a_stepping_off: assert property ( // R8
        @(posedge clk_i) disable iff (!rst_n_i)
        !ctl_o.stepping_en && !command_o[`BPCS_CMD_STEPPING])
        else $error("stepping enabled");

    a_serr_en_write: assert property ( // R9
        @(posedge clk_i) disable iff (!rst_n_i)
        cmd_hi_wr |=> command_o[`BPCS_CMD_SERR_EN] == $past(cfg_req_i.data[8]))
        else $error("system error enable did not follow write");

    a_serr_pin_low: assert property ( // R9
        @(posedge clk_i) disable iff (!rst_n_i)
        primary_system_error_pin_o == 1'h0)
        else $error("system error pin driven high");

    a_serr_on_request: assert property ( // R9
        @(posedge clk_i) disable iff (!rst_n_i)
        primary_system_error_pin_oe_o |-> evt_i.serr_request)
        else $error("system error driven without request");

    a_fb2b_write: assert property ( // R10
        @(posedge clk_i) disable iff (!rst_n_i)
        cmd_hi_wr |=> ctl_o.fast_b2b_en == $past(cfg_req_i.data[9]))
        else $error("fast back-to-back enable did not follow write");

    a_reserved_zero: assert property ( // R11
        @(posedge clk_i) disable iff (!rst_n_i)
        command_o[15:10] == 6'h00)
        else $error("reserved command bits not zero");

    a_cap_list_one: assert property ( // R12
        @(posedge clk_i) disable iff (!rst_n_i)
        status_o[`BPCS_STS_CAP_LIST])
        else $error("capability list bit not one");

    a_66mhz_one: assert property ( // R13
        @(posedge clk_i) disable iff (!rst_n_i)
        status_o[`BPCS_STS_66MHZ])
        else $error("66 MHz bit not one");

    a_fb2b_cap_one: assert property ( // R14
        @(posedge clk_i) disable iff (!rst_n_i)
        status_o[`BPCS_STS_FB2B_CAP])
        else $error("fast back-to-back capable bit not one");

    a_dpe_cleared: assert property ( // R15
        @(posedge clk_i) disable iff (!rst_n_i)
        (sts_b2_wr && cfg_req_i.data[24] && !perr_pin_seen) |=> !status_o[`BPCS_STS_DPE_MSTR])
        else $error("parity pin flag not cleared");

    a_sig_tabort_clear: assert property ( // R17
        @(posedge clk_i) disable iff (!rst_n_i)
        (sts_b3_wr && cfg_req_i.data[27] && !evt_i.sig_target_abort) |=> !status_o[`BPCS_STS_SIG_TABORT])
        else $error("signalled abort flag not cleared");

    a_rcv_tabort_sets: assert property ( // R18
        @(posedge clk_i) disable iff (!rst_n_i)
        evt_i.rcv_target_abort |=> status_o[`BPCS_STS_RCV_TABORT])
        else $error("received target abort lost");

    a_rcv_mabort_sets: assert property ( // R19
        @(posedge clk_i) disable iff (!rst_n_i)
        evt_i.rcv_master_abort |=> status_o[`BPCS_STS_RCV_MABORT])
        else $error("received master abort lost");

    a_serr_gated: assert property ( // R20
        @(posedge clk_i) disable iff (!rst_n_i)
        (!status_o[`BPCS_STS_SIG_SERR] && !command_o[`BPCS_CMD_SERR_EN]) |=> !status_o[`BPCS_STS_SIG_SERR])
        else $error("system error flag set while driver off");

    a_perr_any: assert property ( // R21
        @(posedge clk_i) disable iff (!rst_n_i)
        (evt_i.parity_detected && !command_o[`BPCS_CMD_PERR_RESP]) |=> status_o[`BPCS_STS_DET_PERR])
        else $error("parity flag gated by response bit");

    a_w0_keeps_perr: assert property ( // R22
        @(posedge clk_i) disable iff (!rst_n_i)
        (status_o[`BPCS_STS_DET_PERR] && !(sts_b3_wr && cfg_req_i.data[31])) |=> status_o[`BPCS_STS_DET_PERR])
        else $error("parity flag dropped without write one");

    a_ack_idle: assert property ( // R23
        @(posedge clk_i) disable iff (!rst_n_i)
        !cfg_req_i.valid |=> !cfg_ack_o)
        else $error("answer without access");

    a_other_idx_zero: assert property ( // R23
        @(posedge clk_i) disable iff (!rst_n_i)
        (cfg_req_i.valid && cfg_req_i.idx != `BPCS_IDX_CMD_STS) |=> cfg_rdata_o == 32'h0000_0000)
        else $error("other dword read not zero");

    a_write_reads_zero: assert property ( // R23
        @(posedge clk_i) disable iff (!rst_n_i)
        (cfg_req_i.valid && cfg_req_i.write) |=> cfg_rdata_o == 32'h0000_0000)
        else $error("write answer data not zero");

    a_other_idx_keeps: assert property ( // R23
        @(posedge clk_i) disable iff (!rst_n_i)
        (cfg_req_i.valid && cfg_req_i.idx != `BPCS_IDX_CMD_STS) |=> $stable(command_o))
        else $error("command changed by other dword");

    a_read_view: assert property ( // R23
        @(posedge clk_i) disable iff (!rst_n_i)
        rd_hit |=> cfg_rdata_o == {$past(status_o), $past(command_o)})
        else $error("read data not the register view");

endmodule : bpcs_cmd_status

`default_nettype wire

// [src/bpcs_defines.svh]
// offsets, field positions, reset values and constants of the primary
// command/status register pair; included by the package and the design.
// Contract
// [R1] bit 0 enables primary I/O target response
// [R2] bit 1 enables primary memory target response
// [R3] bit 2 enables mastering, secondary memory/IO response
// [R4] bit 3 reads zero, no special cycles
// [R5] bit 4 reads zero, no memory-write-invalidate
// [R6] bit 5 decodes palette writes 3C6h/3C8h/3C9h
// [R7] bit 6 enables normal parity error actions
// [R8] bit 7 stepping, read-only zero
// [R9] bit 8 enables system error driver
// [R10] bit 9 enables fast back-to-back issue
// [R11] bits 15:10 reserved, read zero
// [R12] bit 20 reads one, capability list
// [R13] bit 21 reads one, 66 MHz capable
// [R14] bit 23 reads one, fast back-to-back capable
// [R15] bit 24 set on parity pin with bit 6
// [R16] bits 26:25 read 01, medium select timing
// [R17] bit 27 set on signalled target abort
// [R18] bit 28 set on received target abort
// [R19] bit 29 set on received master abort
// [R20] bit 30 set when system error asserted
// [R21] bit 31 set on any detected parity error
// [R22] write one clears flag, set wins
// [R23] registers live in 64-byte config header
`ifndef BPCS_DEFINES_SVH
`define BPCS_DEFINES_SVH

`define BPCS_HDR_BYTES      7'h40
`define BPCS_IDX_W          4
`define BPCS_OFS_CMD_STS    6'h04
`define BPCS_IDX_CMD_STS    4'h1
`define BPCS_CAP_PTR_OFS    6'h34

`define BPCS_CMD_IO_EN      0
`define BPCS_CMD_MEM_EN     1
`define BPCS_CMD_MASTER_EN  2
`define BPCS_CMD_SPECIAL    3
`define BPCS_CMD_MWI        4
`define BPCS_CMD_VGA_SNOOP  5
`define BPCS_CMD_PERR_RESP  6
`define BPCS_CMD_STEPPING   7
`define BPCS_CMD_SERR_EN    8
`define BPCS_CMD_FB2B_EN    9
`define BPCS_CMD_WR_MASK    16'h0367
`define BPCS_CMD_RESET      16'h0000

`define BPCS_STS_CAP_LIST   4
`define BPCS_STS_66MHZ      5
`define BPCS_STS_FB2B_CAP   7
`define BPCS_STS_DPE_MSTR   8
`define BPCS_STS_SIG_TABORT 11
`define BPCS_STS_RCV_TABORT 12
`define BPCS_STS_RCV_MABORT 13
`define BPCS_STS_SIG_SERR   14
`define BPCS_STS_DET_PERR   15
`define BPCS_STS_FIXED      16'h02b0
`define BPCS_STS_W1C_MASK   16'hf900
`define BPCS_STS_RESET      16'h0000

`define BPCS_VGA_A0         10'h3c6
`define BPCS_VGA_A1         10'h3c8
`define BPCS_VGA_A2         10'h3c9

`endif

// [src/bpcs_pkg.sv]
// types shared by the primary command/status block.
// assumes bpcs_defines.svh is on the include path.
`include "bpcs_defines.svh"
`default_nettype none

package bpcs_pkg;

    // one configuration access, already claimed for this device
    typedef struct packed {
        logic                     valid;
        logic                     write;
        logic [`BPCS_IDX_W-1:0]   idx;
        logic [3:0]               be;
        logic [31:0]              data;
    } bpcs_cfg_req_type;

    // one-cycle event pulses from the primary interface logic
    typedef struct packed {
        logic sig_target_abort;
        logic rcv_target_abort;
        logic rcv_master_abort;
        logic parity_detected;
        logic serr_request;
    } bpcs_evt_type;

    // decode permissions handed to the bus engines
    typedef struct packed {
        logic io_target_en;
        logic mem_target_en;
        logic master_en;
        logic parity_resp_en;
        logic fast_b2b_en;
        logic stepping_en;
    } bpcs_ctl_type;

endpackage : bpcs_pkg

`default_nettype wire
